/* File: design/ttr_pkg.sv */
package ttr_pkg;

	localparam int PTR_W  = 22;
	localparam int ADDR_W = 21;

	// ------------------------------------------------------------
	// register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_LATCH  = 8'h00;
	localparam logic [7:0] OFF_PTR_LO = 8'h04;
	localparam logic [7:0] OFF_RSC    = 8'h08;
	localparam logic [7:0] OFF_PTR_HI = 8'h0C;
	localparam logic [7:0] OFF_PTR_UP = 8'h10;
	localparam logic [7:0] OFF_STATUS = 8'h14;

	// ------------------------------------------------------------
	// reset_source_control fields
	// ------------------------------------------------------------
	localparam int BIT_PRIO  = 7;
	localparam int BIT_LONG  = 6;
	localparam int BIT_UNIM  = 5;
	localparam int BIT_RSTOP = 4;
	localparam int BIT_TMO   = 3;
	localparam int BIT_PWRDN = 2;
	localparam int BIT_POR   = 1;
	localparam int BIT_BROWN = 0;

	localparam logic [7:0]  RSC_RST      = 8'h1C;
	localparam logic [7:0]  BYTE_ZERO    = 8'h00;
	localparam logic [20:0] ADDR_ONE     = 21'h00_0001;
	localparam logic [21:0] PTR_RST      = 22'h00_0000;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		TTR_PLAIN,
		TTR_POST_INC,
		TTR_POST_DEC,
		TTR_PRE_INC
	} ttr_mode_e;

	typedef enum logic {
		TTR_IDLE,
		TTR_MEM
	} ttr_state_e;

	typedef struct packed {
		logic      write;
		ttr_mode_e mode;
	} ttr_op_s;

	typedef struct packed {
		logic [21:0] addr;
		logic        write;
		logic        long_wr;
		logic [15:0] wdata;
	} ttr_mreq_s;

	typedef struct packed {
		logic por;
		logic brownout;
		logic master_clear;
		logic watchdog_timeout;
		logic reset_op;
		logic watchdog_clear_op;
		logic sleep_op;
	} ttr_rst_evt_s;

endpackage

/* File: design/ttr_table_xfer.sv */
`timescale 1ns/1ps
module ttr_table_xfer #(
	parameter int INT_MEM_BYTES = 65536
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [7:0]        s_axi_awaddr,
	input  wire logic [2:0]        s_axi_awprot,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	output logic [1:0]             s_axi_bresp,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	input  wire logic [7:0]        s_axi_araddr,
	input  wire logic [2:0]        s_axi_arprot,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	input  wire logic              op_valid,
	output logic                   op_ready,
	input  wire ttr_pkg::ttr_op_s  op,
	output logic                   op_done,
	output logic                   mem_req_valid,
	output ttr_pkg::ttr_mreq_s     mem_req,
	input  wire logic              mem_ack,
	input  wire logic [7:0]        mem_rdata,
	input  wire ttr_pkg::ttr_rst_evt_s rst_evt,
	input  wire logic              brownout_circuit_enable,
	input  wire logic              vpp_present,
	output logic                   irq_priority_enable
);
	import ttr_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	ttr_state_e  state_q, state_d;
	ttr_mode_e   mode_q, mode_d;
	ttr_mreq_s   mreq_q, mreq_d;
	logic        mvalid_q, mvalid_d;
	logic        done_q, done_d;
	logic [21:0] ptr_q, ptr_d;
	logic [7:0]  latch_q, latch_d;
	logic [7:0]  hold_q, hold_d;
	logic [7:0]  rsc_q, rsc_d;
	logic        bvalid_q, bvalid_d;
	logic [1:0]  bresp_q, bresp_d;
	logic        rvalid_q, rvalid_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0]  rresp_q, rresp_d;

	logic        wr_go, rd_go, op_acc;
	logic        wr_latch, wr_lo, wr_hi, wr_up, wr_rsc, wr_map;
	logic [7:0]  wbyte;
	logic [21:0] xfer_addr;
	logic        xfer_ext, long_ok;

	// post-transfer pointer update; only the low 21 bits move, wrapping with no carry into bit 21
	function automatic logic [21:0] ttr_post(input logic [21:0] p, input ttr_mode_e m);
		logic [21:0] r;
		r = p;
		case (m)
			TTR_POST_INC: r = {p[21], p[20:0] + ADDR_ONE};
			TTR_POST_DEC: r = {p[21], p[20:0] - ADDR_ONE};
			default:      r = p;
		endcase
		return r;
	endfunction

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	assign wr_go         = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
	assign rd_go         = s_axi_arvalid && !rvalid_q;
	assign s_axi_awready = wr_go;
	assign s_axi_wready  = wr_go;
	assign s_axi_arready = rd_go;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;

	// byte lane 0 carries every register; other lanes are ignored
	assign wbyte    = s_axi_wdata[7:0];
	assign wr_latch = wr_go && s_axi_wstrb[0] && (s_axi_awaddr == OFF_LATCH);
	assign wr_lo    = wr_go && s_axi_wstrb[0] && (s_axi_awaddr == OFF_PTR_LO);
	assign wr_hi    = wr_go && s_axi_wstrb[0] && (s_axi_awaddr == OFF_PTR_HI);
	assign wr_up    = wr_go && s_axi_wstrb[0] && (s_axi_awaddr == OFF_PTR_UP);
	assign wr_rsc   = wr_go && s_axi_wstrb[0] && (s_axi_awaddr == OFF_RSC);
	assign wr_map   = (s_axi_awaddr == OFF_LATCH) || (s_axi_awaddr == OFF_PTR_LO)
		|| (s_axi_awaddr == OFF_PTR_HI) || (s_axi_awaddr == OFF_PTR_UP)
		|| (s_axi_awaddr == OFF_RSC) || (s_axi_awaddr == OFF_STATUS);

	// ------------------------------------------------------------
	// table transfer engine
	// ------------------------------------------------------------
	assign op_ready      = (state_q == TTR_IDLE);
	assign op_acc        = op_valid && op_ready;
	assign op_done       = done_q;
	assign mem_req_valid = mvalid_q;
	assign mem_req       = mreq_q;
	assign irq_priority_enable = rsc_q[BIT_PRIO];

	// pre-increment moves the pointer before the address is used
	assign xfer_addr = (op.mode == TTR_PRE_INC)
		? {ptr_q[21], ptr_q[20:0] + ADDR_ONE} : ptr_q;
	// identity/configuration space counts as on-chip memory
	assign xfer_ext  = !xfer_addr[21]
		&& (xfer_addr[20:0] >= ADDR_W'(INT_MEM_BYTES));
	assign long_ok   = rsc_q[BIT_LONG] && vpp_present;

	always_comb begin
		state_d  = state_q;
		mode_d   = mode_q;
		mreq_d   = mreq_q;
		mvalid_d = mvalid_q;
		done_d   = 1'b0;
		ptr_d    = ptr_q;
		latch_d  = latch_q;
		hold_d   = hold_q;
		case (state_q)
			TTR_IDLE: begin
				if (op_acc) begin
					mode_d = op.mode;
					if (op.write && !xfer_ext && !xfer_addr[0]) begin
						// short write: byte parks in the hidden holding register
						hold_d = latch_q;
						ptr_d  = ttr_post(xfer_addr, op.mode);
						done_d = 1'b1;
					end else if (op.write && !xfer_ext && !long_ok) begin
						// odd write without enable: nothing is programmed
						ptr_d  = ttr_post(xfer_addr, op.mode);
						done_d = 1'b1;
					end else begin
						mreq_d.addr    = xfer_addr;
						mreq_d.write   = op.write;
						mreq_d.long_wr = op.write && !xfer_ext;
						// external writes go out a byte at a time, enable ignored
						mreq_d.wdata   = xfer_ext ? {BYTE_ZERO, latch_q}
							: {latch_q, hold_q};
						mvalid_d       = 1'b1;
						ptr_d          = xfer_addr;
						state_d        = TTR_MEM;
					end
				end
			end
			TTR_MEM: begin
				if (mem_ack) begin
					mvalid_d = 1'b0;
					if (!mreq_q.write) latch_d = mem_rdata;
					ptr_d   = ttr_post(ptr_q, mode_q);
					done_d  = 1'b1;
					state_d = TTR_IDLE;
				end
			end
			default: begin
				state_d  = TTR_IDLE;
				mvalid_d = 1'b0;
			end
		endcase
		// a software write to the pointer or latch dominates the auto-update
		if (wr_latch) latch_d = wbyte;
		if (wr_lo) ptr_d[7:0] = wbyte;
		if (wr_hi) ptr_d[15:8] = wbyte;
		if (wr_up) ptr_d[21:16] = wbyte[5:0];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q  <= TTR_IDLE;
			mode_q   <= TTR_PLAIN;
			mreq_q   <= '0;
			mvalid_q <= 1'b0;
			done_q   <= 1'b0;
			ptr_q    <= PTR_RST;
			latch_q  <= BYTE_ZERO;
			hold_q   <= BYTE_ZERO;
		end else begin
			state_q  <= state_d;
			mode_q   <= mode_d;
			mreq_q   <= mreq_d;
			mvalid_q <= mvalid_d;
			done_q   <= done_d;
			ptr_q    <= ptr_d;
			latch_q  <= latch_d;
			hold_q   <= hold_d;
		end
	end

	// ------------------------------------------------------------
	// reset source flags
	// ------------------------------------------------------------
	// software first, hardware events after, so an event never gets lost
	always_comb begin
		rsc_d = rsc_q;
		if (wr_rsc) begin
			rsc_d[BIT_PRIO]  = wbyte[BIT_PRIO];
			rsc_d[BIT_LONG]  = rsc_q[BIT_LONG] | wbyte[BIT_LONG];
			rsc_d[BIT_RSTOP] = wbyte[BIT_RSTOP];
			rsc_d[BIT_TMO]   = wbyte[BIT_TMO];
			rsc_d[BIT_PWRDN] = wbyte[BIT_PWRDN];
			rsc_d[BIT_POR]   = wbyte[BIT_POR];
			rsc_d[BIT_BROWN] = wbyte[BIT_BROWN];
		end
		if (rst_evt.watchdog_clear_op || rst_evt.sleep_op) rsc_d[BIT_TMO] = 1'b1;
		if (rst_evt.watchdog_clear_op) rsc_d[BIT_PWRDN] = 1'b1;
		if (rst_evt.sleep_op) rsc_d[BIT_PWRDN] = 1'b0;
		if (rst_evt.por || rst_evt.master_clear) begin
			rsc_d[BIT_PRIO] = 1'b0;
			rsc_d[BIT_LONG] = 1'b0;
		end
		if (rst_evt.por) begin
			rsc_d[BIT_RSTOP] = 1'b1;
			rsc_d[BIT_TMO]   = 1'b1;
			rsc_d[BIT_PWRDN] = 1'b1;
			rsc_d[BIT_POR]   = 1'b0;
			// with the brown-out circuit off the flag is left as it was
			if (brownout_circuit_enable) rsc_d[BIT_BROWN] = 1'b1;
		end
		if (rst_evt.brownout) rsc_d[BIT_BROWN] = 1'b0;
		if (rst_evt.watchdog_timeout) rsc_d[BIT_TMO] = 1'b0;
		if (rst_evt.reset_op) rsc_d[BIT_RSTOP] = 1'b0;
		rsc_d[BIT_UNIM] = 1'b0;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rsc_q <= RSC_RST;
		end else begin
			rsc_q <= rsc_d;
		end
	end

	// ------------------------------------------------------------
	// bus responses
	// ------------------------------------------------------------
	always_comb begin
		bvalid_d = bvalid_q;
		bresp_d  = bresp_q;
		rvalid_d = rvalid_q;
		rdata_d  = rdata_q;
		rresp_d  = rresp_q;
		if (bvalid_q && s_axi_bready) bvalid_d = 1'b0;
		if (wr_go) begin
			bvalid_d = 1'b1;
			bresp_d  = wr_map ? RESP_OKAY : RESP_SLVERR;
		end
		if (rvalid_q && s_axi_rready) rvalid_d = 1'b0;
		if (rd_go) begin
			rvalid_d = 1'b1;
			rresp_d  = RESP_OKAY;
			rdata_d  = '0;
			case (s_axi_araddr)
				OFF_LATCH:  rdata_d[7:0] = latch_q;
				OFF_PTR_LO: rdata_d[7:0] = ptr_q[7:0];
				OFF_PTR_HI: rdata_d[7:0] = ptr_q[15:8];
				OFF_PTR_UP: rdata_d[5:0] = ptr_q[21:16];
				OFF_RSC:    rdata_d[7:0] = rsc_q;
				OFF_STATUS: rdata_d[2:0] = {long_ok, vpp_present, !op_ready};
				default:    rresp_d = RESP_SLVERR;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
			rvalid_q <= 1'b0;
			rdata_q  <= '0;
			rresp_q  <= RESP_OKAY;
		end else begin
			bvalid_q <= bvalid_d;
			bresp_q  <= bresp_d;
			rvalid_q <= rvalid_d;
			rdata_q  <= rdata_d;
			rresp_q  <= rresp_d;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic ptr_bus_wr;
	assign ptr_bus_wr = wr_lo || wr_hi || wr_up;

	property p_pre_inc;
		op_acc && !op.write && (op.mode == TTR_PRE_INC) |=>
			mem_req_valid && (mem_req.addr[20:0] == $past(ptr_q[20:0]) + ADDR_ONE);
	endproperty
	a_pre_inc: assert property (p_pre_inc) else $error("pre-increment address wrong");
	property p_post_inc;
		(state_q == TTR_MEM) && mem_ack && (mode_q == TTR_POST_INC) && !ptr_bus_wr |=>
			ptr_q[20:0] == $past(mreq_q.addr[20:0]) + ADDR_ONE;
	endproperty
	a_post_inc: assert property (p_post_inc) else $error("post-increment missed");
	property p_post_dec;
		(state_q == TTR_MEM) && mem_ack && (mode_q == TTR_POST_DEC) && !ptr_bus_wr |=>
			ptr_q[20:0] == $past(mreq_q.addr[20:0]) - ADDR_ONE;
	endproperty
	a_post_dec: assert property (p_post_dec) else $error("post-decrement missed");
	property p_plain;
		(op_acc && (op.mode == TTR_PLAIN) && !ptr_bus_wr |=> (ptr_q == $past(ptr_q)))
			and ((state_q == TTR_MEM) && mem_ack && (mode_q == TTR_PLAIN) && !ptr_bus_wr
			|=> (ptr_q == $past(ptr_q)));
	endproperty
	a_plain: assert property (p_plain) else $error("plain transfer moved pointer");
	property p_top_bit;
		!wr_up |=> ptr_q[21] == $past(ptr_q[21]);
	endproperty
	a_top_bit: assert property (p_top_bit) else $error("top pointer bit changed");
	// back-to-back ops are legal, so idle is checked in the cycle the latch lands
	property p_latch_load;
		(state_q == TTR_MEM) && mem_ack && !mreq_q.write && !wr_latch |=>
			latch_q == $past(mem_rdata) && op_ready;
	endproperty
	a_latch_load: assert property (p_latch_load) else $error("latch not loaded");
	property p_long_sticky;
		rsc_q[BIT_LONG] && !rst_evt.por && !rst_evt.master_clear |=> rsc_q[BIT_LONG];
	endproperty
	a_long_sticky: assert property (p_long_sticky) else $error("long write enable lost");
	property p_long_gate;
		$rose(mem_req_valid) && mem_req.long_wr |-> $past(long_ok) && mem_req.addr[0];
	endproperty
	a_long_gate: assert property (p_long_gate) else $error("ungated long write");
	property p_even_hold;
		op_acc && op.write && !xfer_ext && !xfer_addr[0] |=>
			(hold_q == $past(latch_q)) && !mem_req_valid && op_done;
	endproperty
	a_even_hold: assert property (p_even_hold) else $error("even write not held");
	property p_ext_write;
		op_acc && op.write && xfer_ext |=> mem_req_valid && mem_req.write && !mem_req.long_wr;
	endproperty
	a_ext_write: assert property (p_ext_write) else $error("external write blocked");
	property p_flags;
		(rst_evt.watchdog_timeout |=> !rsc_q[BIT_TMO])
			and (rst_evt.reset_op |=> !rsc_q[BIT_RSTOP] && !rsc_q[BIT_UNIM]);
	endproperty
	a_flags: assert property (p_flags) else $error("reset flag not cleared");
	property p_por_flag;
		rst_evt.por && !rst_evt.brownout |=>
			!rsc_q[BIT_POR] && rsc_q[BIT_PWRDN] && !rsc_q[BIT_LONG];
	endproperty
	a_por_flag: assert property (p_por_flag) else $error("power-on flags wrong");
	property p_sleep_pwrdn;
		rst_evt.sleep_op && !rst_evt.por |=> !rsc_q[BIT_PWRDN];
	endproperty
	a_sleep_pwrdn: assert property (p_sleep_pwrdn) else $error("sleep kept power-down flag");

	c_read: cover property (op_acc && !op.write ##[1:20] op_done);
	c_long: cover property ($rose(mem_req_valid) && mem_req.long_wr);
	c_ext:  cover property (op_acc && op.write && xfer_ext);

endmodule

/* File: tb/table_transfer_reset_flags_test.sv */
`timescale 1ns/1ps
module table_transfer_reset_flags_test;
	import ttr_pkg::*;
	logic aclk = 0, aresetn = 0, slow = 0, vpp = 0, bce = 1;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, op_valid = 0;
	logic awready, wready, bvalid, arready, rvalid, op_ready, op_done, prio_en, mreq_v, mack;
	logic [7:0]   awaddr = 8'h00, araddr = 8'h00, mrd, n_req;
	logic [31:0]  wdata = 32'h0000_0000, rdata;
	logic [1:0]   bresp, rresp;
	ttr_op_s      op = '0;
	ttr_rst_evt_s rst_evt = '0;
	ttr_mreq_s    mreq, last;
	int           failures = 0, n_checks = 0, cyc = 0;

	ttr_table_xfer dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .op_valid(op_valid), .op_ready(op_ready), .op(op),
		.op_done(op_done), .mem_req_valid(mreq_v), .mem_req(mreq), .mem_ack(mack),
		.mem_rdata(mrd), .rst_evt(rst_evt), .brownout_circuit_enable(bce),
		.vpp_present(vpp), .irq_priority_enable(prio_en));

	ttr_mem_model mem (.aclk(aclk), .aresetn(aresetn), .slow(slow), .mem_req_valid(mreq_v),
		.mem_req(mreq), .mem_ack(mack), .mem_rdata(mrd), .last_q(last), .n_req_q(n_req));

	always #20 aclk = ~aclk;

	// ------------------------------
	// bus and compare tasks
	// ------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do @(posedge aclk); while (awready !== 1'b1 || wready !== 1'b1);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do @(posedge aclk); while (bvalid !== 1'b1);
		bready <= 1'b0;
		r = bresp;
	endtask
	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rready <= 1'b0;
		d = rdata;
		r = rresp;
	endtask
	task automatic set_ptr(input logic [21:0] p);
		logic [1:0] r;
		axw(OFF_PTR_UP, {26'h0, p[21:16]}, r);
		axw(OFF_PTR_HI, {24'h0, p[15:8]}, r);
		axw(OFF_PTR_LO, {24'h0, p[7:0]}, r);
	endtask
	task automatic get_ptr(output logic [31:0] p);
		logic [31:0] u, h, l;
		logic [1:0]  r;
		axr(OFF_PTR_UP, u, r);
		axr(OFF_PTR_HI, h, r);
		axr(OFF_PTR_LO, l, r);
		p = (u << 16) | (h << 8) | l;
	endtask
	task automatic run_op(input logic w, input ttr_mode_e m);
		@(posedge aclk);
		op <= '{write: w, mode: m};
		op_valid <= 1'b1;
		do @(posedge aclk); while (op_ready !== 1'b1);
		op_valid <= 1'b0;
		do @(posedge aclk); while (op_done !== 1'b1);
	endtask
	function automatic logic [7:0] exp_b(input logic [21:0] a);
		return a[7:0] ^ a[15:8] ^ {2'h0, a[21:16]} ^ 8'hC3;
	endfunction

	// ------------------------------
	// scenarios
	// ------------------------------
	task automatic t_reset();
		logic [31:0] d;
		logic [1:0]  r;
		axr(OFF_RSC, d, r);
		chk("rsc reset", 32'h0000_001C, d);
		chk("prio pin", 32'h0, prio_en);
		axr(8'h18, d, r);
		chk("unmapped rd", {30'h0, RESP_SLVERR}, {d[29:0], r});
		axw(8'h1C, 32'h0000_00FF, r);
		chk("unmapped wr", RESP_SLVERR, r);
		set_ptr(22'h2A_5A3C);
		get_ptr(d);
		chk("ptr rw", 32'h002A_5A3C, d);
	endtask
	task automatic t_modes();
		logic [21:0] st[2] = '{22'h3F_FFFF, 22'h00_00FF};
		logic [21:0] p, a, n;
		logic [31:0] d;
		logic [1:0]  r;
		ttr_mode_e   m;
		for (int s = 0; s < 2; s++) begin
			p = st[s];
			set_ptr(p);
			for (int k = 0; k < 4; k++) begin
				m = ttr_mode_e'((k + 1) % 4);
				slow <= k[0];
				a = (m == TTR_PRE_INC) ? {p[21], p[20:0] + ADDR_ONE} : p;
				n = (m == TTR_PLAIN) ? p : (m == TTR_POST_DEC) ?
					{p[21], p[20:0] - ADDR_ONE} : {p[21], p[20:0] + ADDR_ONE};
				run_op(1'b0, m);
				chk("rd addr", a, last.addr);
				axr(OFF_LATCH, d, r);
				chk("latch", exp_b(a), d);
				get_ptr(d);
				chk("ptr next", n, d);
				p = n;
			end
		end
	endtask
	task automatic t_write();
		logic [31:0] d;
		logic [1:0]  r;
		logic [7:0]  c;
		axw(OFF_RSC, 32'h0000_005F, r);
		vpp <= 1'b1;
		set_ptr(22'h00_0010);
		axr(OFF_STATUS, d, r);
		chk("status", 32'h0000_0006, d);
		axw(OFF_LATCH, 32'h0000_00A5, r);
		c = n_req;
		run_op(1'b1, TTR_POST_INC);
		chk("even wr", c, n_req);
		axw(OFF_LATCH, 32'h0000_005A, r);
		run_op(1'b1, TTR_PLAIN);
		chk("long addr", 32'h11, last.addr);
		chk("long data", 32'h5AA5, last.wdata);
		chk("long kind", 2'b11, {last.write, last.long_wr});
		get_ptr(d);
		chk("ptr plain", 32'h11, d);
		vpp <= 1'b0;
		c = n_req;
		run_op(1'b1, TTR_PLAIN);
		chk("no vpp", c, n_req);
		set_ptr(22'h01_0001);
		axw(OFF_LATCH, 32'h0000_0077, r);
		run_op(1'b1, TTR_POST_DEC);
		chk("ext data", 32'h0077, last.wdata);
		chk("ext kind", 2'b10, {last.write, last.long_wr});
		get_ptr(d);
		chk("ptr dec", 32'h0001_0000, d);
	endtask
	task automatic t_flags();
		logic [6:0]  ev[9] = '{7'h08, 7'h01, 7'h02, 7'h04, 7'h20, 7'h10, 7'h40, 7'h20, 7'h40};
		logic [7:0]  ex[9] = '{8'hD7, 8'hDB, 8'hDF, 8'hCF, 8'hCE, 8'h0E, 8'h1D, 8'h1C, 8'h1C};
		logic [31:0] d;
		logic [1:0]  r;
		axw(OFF_RSC, 32'h0000_00FF, r);
		axw(OFF_RSC, 32'h0000_009F, r);
		axr(OFF_RSC, d, r);
		chk("rsc sw", 32'h0000_00DF, d);
		chk("prio on", 32'h1, prio_en);
		// the last power-on runs with the brown-out circuit off: flag must stay clear
		for (int i = 0; i < 9; i++) begin
			@(posedge aclk);
			rst_evt <= ev[i];
			bce <= (i != 8);
			@(posedge aclk);
			rst_evt <= '0;
			axr(OFF_RSC, d, r);
			chk("rsc evt", {24'h0, ex[i]}, d);
		end
		chk("prio off", 32'h0, prio_en);
	endtask

	task automatic close_out();
		if (failures == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// a hung handshake ends the run here instead of spinning forever
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 5000) begin
			failures++;
			close_out();
		end
	end

	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_modes();
		t_write();
		t_flags();
		close_out();
	end
endmodule

/* File: tb/ttr_mem_model.sv */
`timescale 1ns/1ps
// ------------------------------
// program memory array model
// ------------------------------
module ttr_mem_model (
	input  wire logic               aclk,
	input  wire logic               aresetn,
	input  wire logic               slow,
	input  wire logic               mem_req_valid,
	input  wire ttr_pkg::ttr_mreq_s mem_req,
	output logic                    mem_ack,
	output logic [7:0]              mem_rdata,
	output ttr_pkg::ttr_mreq_s      last_q,
	output logic [7:0]              n_req_q
);
	import ttr_pkg::*;
	logic [1:0] wait_q;
	logic [1:0] wait_d;
	logic [7:0] byte_q;
	logic [7:0] byte_d;
	logic       ack_d;
	// each byte follows its address, so a wrong pointer shows up in the latch
	always_comb begin
		wait_d = (mem_req_valid && !mem_ack) ? wait_q + 2'h1 : 2'h0;
		ack_d  = mem_req_valid && !mem_ack && (!slow || wait_q == 2'h3);
		byte_d = byte_q;
		if (ack_d) begin
			byte_d = mem_req.addr[7:0] ^ mem_req.addr[15:8] ^ {2'h0, mem_req.addr[21:16]} ^ 8'hC3;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wait_q <= 2'h0;
			mem_ack <= 1'b0;
			byte_q <= 8'h00;
			n_req_q <= 8'h00;
			last_q <= '0;
		end else begin
			wait_q <= wait_d;
			mem_ack <= ack_d;
			byte_q <= byte_d;
			if (mem_ack) begin
				last_q <= mem_req;
				n_req_q <= n_req_q + 8'h01;
			end
		end
	end
	// outside the ack cycle the bus is released: show the inverse, never a stale byte
	assign mem_rdata = mem_ack ? byte_q : ~byte_q;
endmodule
